// ==== testbench/sphp_peer_model.sv ====
/* Peripheral on the pin side: sends bytes by strobe, takes bytes by acknowledge.
   Assumes tasks are called from the bench after reset; released lines pull high. */
`timescale 1ns/100ps
`default_nettype none
module sphp_peer_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] busIn,
  output var  logic       strobeN,
  output var  logic       ackN,
  output var  logic       peerOe,
  output var  logic [7:0] peerData
);
  initial
  begin
    strobeN = 1'b1;
    ackN = 1'b1;
    peerOe = 1'b0;
    peerData = 8'hFF;
  end
  // ==========
  // Data held three cycles past the rise: the latch follows until sync catches up
  task sendByte(input logic [7:0] d, input int hold);
    @(posedge clk_sys);
    #2 peerData = d;
    peerOe = 1'b1;
    @(posedge clk_sys);
    #2 strobeN = 1'b0;
    repeat (hold) @(posedge clk_sys);
    #2 strobeN = 1'b1;
    repeat (3) @(posedge clk_sys);
    #2 peerOe = 1'b0;
    peerData = ~d;
  endtask
  task ackByte(input int hold, output logic [7:0] got);
    @(posedge clk_sys);
    #2 ackN = 1'b0;
    repeat (hold) @(posedge clk_sys);
    #2 got = busIn;
    ackN = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== testbench/sphp_port_properties.sv ====
/* Timing checker for the strobed handshake port.
   Assumes a bind onto sphp_port and pins that change away from clk_sys edges. */
`timescale 1ns/100ps
`default_nettype none
module sphp_port_properties (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [1:0] hostMode,
  input wire logic       hostInEnable,
  input wire logic       hostOutEnable,
  input wire logic       hostRdN,
  input wire logic       hostWrN,
  input wire logic [7:0] hostWrData,
  input wire logic       serviceRequest,
  input wire logic [7:0] ctlIn,
  input wire logic [7:0] ctlOut,
  input wire logic [7:0] ctlOe,
  input wire logic [7:0] dataOut,
  input wire logic [7:0] dataOe,
  input wire logic [7:0] gpioOe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========
  // Pin edges pass two sync flops, so answers allow up to four samples
  a_strobe_sets_full: assert property (hostMode[0] && $fell(ctlIn[4]) |-> ##[1:4] ctlOut[5])
    else $error("input full flag late");
  a_strobe_raises_req: assert property (
    hostMode == 2'h1 && hostInEnable && $rose(ctlIn[4]) |-> ##[1:4] serviceRequest)
    else $error("input request late");
  a_read_drops_req: assert property (hostMode == 2'h1 && $fell(hostRdN) |-> ##[1:2] !serviceRequest)
    else $error("request not cleared by read");
  a_write_loads_byte: assert property (
    hostMode == 2'h2 && $rose(hostWrN) |-> ##[1:2] !ctlOut[7] && dataOut == hostWrData)
    else $error("written byte not presented");
  a_ack_frees_buffer: assert property (hostMode[1] && $fell(ctlIn[6]) |-> ##[1:4] ctlOut[7])
    else $error("output full flag not returned");
  a_ack_raises_req: assert property (
    hostMode == 2'h2 && hostOutEnable && $rose(ctlIn[6]) |-> ##[1:4] serviceRequest)
    else $error("output request late");
  a_bus_drive_ack: assert property ((hostMode == 2'h3 && !ctlIn[6]) [*4] |-> dataOe == 8'hFF)
    else $error("bus not driven under acknowledge");
  a_bus_float: assert property (
    hostMode == 2'h3 && $rose(ctlIn[6]) |=> dataOe == 8'hFF ##[1:4] dataOe == 8'h00)
    else $error("bus release out of window");
  a_reset_floats: assert property (@(posedge clk_sys) disable iff (1'b0)
    rst |-> (dataOe | ctlOe | gpioOe) == 8'h00)
    else $error("pin driven in reset");
  cover property (hostMode == 2'h1 && $rose(serviceRequest));
  cover property (hostMode == 2'h2 && $rose(ctlOut[7]));
  cover property (hostMode == 2'h3 && $fell(dataOe[0]));
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* Self-checking bench for sphp_port with a peripheral model on the pins.
   Assumes the port, peer model and checker are compiled before this file. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk_sys;
  logic        rst = 1'b0;
  logic        hostRdN = 1'b1, hostWrN = 1'b1, hostInEnable = 1'b0, hostOutEnable = 1'b0;
  logic [1:0]  hostMode = 2'h0, hostNibbleDir = 2'h0;
  logic [7:0]  hostWrData = 8'h00, hostPortDir = 8'h00, hostNibbleOut = 8'h00;
  logic [7:0]  hostGpioDir = 8'h00, hostGpioOut = 8'h00;
  logic [9:0]  hostFuncDir = 10'h000, hostFuncOut = 10'h000;
  wire  [7:0]  hostRdData, hostNibbleIn, hostPortIn, hostGpioIn, dataOut, dataOe, ctlOut, ctlOe, gpioOut, gpioOe;
  wire  [7:0]  dataIn, ctlIn, gpioIn, peerData;
  wire  [9:0]  hostFuncIn, funcOut, funcOe, funcIn;
  wire         serviceRequest, strobeN, ackN, peerOe;
  logic [7:0]  b, got;
  logic [31:0] rnd;
  integer      seed, n_mismatch, total_checks;
  integer      cyc = 0;
  // ==========
  // Pins: undriven lines sit at their pull-up level
  assign dataIn = (dataOut & dataOe) | (~dataOe & (peerOe ? peerData : 8'hFF));
  assign ctlIn  = (ctlOut & ctlOe) | (~ctlOe & {1'b1, ackN, 1'b1, strobeN, 4'hF});
  assign gpioIn = gpioOut | ~gpioOe;
  assign funcIn = funcOut | ~funcOe;
  sphp_port dut (.clk_sys, .rst, .hostMode, .hostInEnable, .hostOutEnable, .hostRdN, .hostWrN, .hostWrData,
    .hostRdData, .serviceRequest, .hostPortDir, .hostNibbleDir, .hostNibbleOut, .hostNibbleIn, .hostPortIn,
    .hostGpioDir, .hostGpioOut, .hostGpioIn, .hostFuncDir, .hostFuncOut, .hostFuncIn, .dataIn, .dataOut,
    .dataOe, .ctlIn, .ctlOut, .ctlOe, .gpioIn, .gpioOut, .gpioOe, .funcIn, .funcOut, .funcOe);
  sphp_peer_model peer (.clk_sys, .busIn(dataIn), .strobeN, .ackN, .peerOe, .peerData);
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  function automatic logic [7:0] nibOe(input logic [1:0] d);
    return {{4{d[1]}}, {4{d[0]}}};
  endfunction
  function automatic logic [7:0] lineIn(input logic [7:0] o, input logic [7:0] d);
    return o | ~d;
  endfunction
  task automatic hostRead(input logic [7:0] e);
    hostRdN = 1'b0;
    tick(2);
    chk1(serviceRequest, 1'b0);
    chk8(hostRdData, e);
    hostRdN = 1'b1;
    tick(2);
    chk1(ctlOut[5], 1'b0);
  endtask
  task automatic hostWrite(input logic [7:0] d);
    hostWrN = 1'b0;
    tick(2);
    chk1(serviceRequest, 1'b0);
    hostWrData = d;
    hostWrN = 1'b1;
    tick(2);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    seed = 75;
    n_mismatch = 0;
    total_checks = 0;
    // Raise reset as an edge so the flops clear before the first clock
    #1 rst = 1'b1;
    tick(3);
    chk8(dataOe | ctlOe | gpioOe | funcOe[7:0], 8'h00);
    tick(3);
    rst = 1'b0;
    tick(2);
    hostMode = 2'h1;
    hostInEnable = 1'b1;
    repeat (4)
    begin
      rnd = $random(seed);
      b = rnd[7:0];
      peer.sendByte(b, 2 + rnd[9:8]);
      tick(1);
      chk1(ctlOut[5], 1'b1);
      chk1(serviceRequest, hostInEnable);
      hostRead(b);
      hostInEnable = ~hostInEnable;
    end
    hostMode = 2'h2;
    hostOutEnable = 1'b1;
    repeat (4)
    begin
      rnd = $random(seed);
      hostWrite(rnd[7:0]);
      chk8(dataOut, rnd[7:0]);
      chk1(ctlOut[7], 1'b0);
      peer.ackByte(2 + rnd[9:8], got);
      chk8(got, rnd[7:0]);
      tick(4);
      chk1(ctlOut[7], 1'b1);
      chk1(serviceRequest, hostOutEnable);
      hostOutEnable = ~hostOutEnable;
    end
    hostMode = 2'h3;
    tick(2);
    rnd = $random(seed);
    hostWrite(rnd[7:0]);
    chk8(dataOe, 8'h00);
    peer.ackByte(5, got);
    chk8(got, rnd[7:0]);
    tick(1);
    chk8(dataOe, 8'hFF);
    tick(4);
    chk8(dataOe, 8'h00);
    peer.sendByte(rnd[15:8], 3);
    tick(1);
    chk1(ctlOut[5], 1'b1);
    hostRead(rnd[15:8]);
    hostMode = 2'h0;
    repeat (4)
    begin
      rnd = $random(seed);
      hostGpioDir = rnd[7:0];
      hostGpioOut = rnd[15:8];
      hostNibbleDir = rnd[17:16];
      hostNibbleOut = rnd[25:18];
      rnd = $random(seed);
      hostPortDir = rnd[7:0];
      hostFuncDir = rnd[17:8];
      hostFuncOut = rnd[27:18];
      tick(4);
      chk8(gpioOe, hostGpioDir);
      chk8(hostGpioIn, lineIn(hostGpioOut, hostGpioDir));
      chk8(ctlOe, nibOe(hostNibbleDir));
      chk8(hostNibbleIn, lineIn(hostNibbleOut, nibOe(hostNibbleDir)));
      chk8(dataOe, hostPortDir);
      chk8(hostPortIn, lineIn(hostNibbleOut, hostPortDir));
      chk8(funcOe[7:0], hostFuncDir[7:0]);
      chk8({6'h00, funcOe[9:8]}, {6'h00, hostFuncDir[9:8]});
      chk8(hostFuncIn[7:0], lineIn(hostFuncOut[7:0], hostFuncDir[7:0]));
    end
    rst = 1'b1;
    tick(1);
    chk8(dataOe | ctlOe | gpioOe | funcOe[7:0] | {6'h00, funcOe[9:8]}, 8'h00);
    test_done;
  end
endmodule
bind sphp_port sphp_port_properties chk (.clk_sys, .rst, .hostMode, .hostInEnable, .hostOutEnable, .hostRdN,
  .hostWrN, .hostWrData, .serviceRequest, .ctlIn, .ctlOut, .ctlOe, .dataOut, .dataOe, .gpioOe);
`default_nettype wire

// ==== verilog/sphp_gpio.v ====
/*
  General-purpose line group with per-line direction.
  Assumes host controls come from logic on clk_sys; pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module sphp_gpio #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire [WIDTH-1:0] hostDir,
  input  wire [WIDTH-1:0] hostOut,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinOut,
  output reg  [WIDTH-1:0] pinOe,
  output wire [WIDTH-1:0] lineIn
);
  // ==========================================================
  // Direction and level per line, floating out of reset
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gLine
      always @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          pinOe[i]  <= 1'b0;
          pinOut[i] <= 1'b0;
        end
        else
        begin
          pinOe[i]  <= hostDir[i];
          pinOut[i] <= hostOut[i];
        end
      end
    end
  endgenerate

  sphp_sync #(
    .WIDTH  (WIDTH),
    .RSTVAL ({WIDTH{1'b1}})
  ) uSync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   (pinIn),
    .syncOut (lineIn)
  );
endmodule
`default_nettype wire

// ==== verilog/sphp_port.v ====
/*
  Strobed parallel handshake port: byte data port, control port carrying
  strobe, acknowledge and flags, plus general-purpose and function lines.
  Assumes host strobes and settings come from logic on clk_sys and that
  all pins are asynchronous to it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sphp_regs.vh"
module sphp_port (
  input  wire        clk_sys,
  input  wire        rst,
  // Host side
  input  wire [1:0]  hostMode,
  input  wire        hostInEnable,
  input  wire        hostOutEnable,
  input  wire        hostRdN,
  input  wire        hostWrN,
  input  wire [7:0]  hostWrData,
  output reg  [7:0]  hostRdData,
  output reg         serviceRequest,
  input  wire [7:0]  hostPortDir,
  input  wire [1:0]  hostNibbleDir,
  input  wire [7:0]  hostNibbleOut,
  output wire [7:0]  hostNibbleIn,
  output wire [7:0]  hostPortIn,
  input  wire [7:0]  hostGpioDir,
  input  wire [7:0]  hostGpioOut,
  output wire [7:0]  hostGpioIn,
  input  wire [9:0]  hostFuncDir,
  input  wire [9:0]  hostFuncOut,
  output wire [9:0]  hostFuncIn,
  // Data port pins
  input  wire [7:0]  dataIn,
  output reg  [7:0]  dataOut,
  output reg  [7:0]  dataOe,
  // Control port pins
  input  wire [7:0]  ctlIn,
  output reg  [7:0]  ctlOut,
  output reg  [7:0]  ctlOe,
  // General-purpose pins
  input  wire [7:0]  gpioIn,
  output wire [7:0]  gpioOut,
  output wire [7:0]  gpioOe,
  // Programmable-function pins
  input  wire [9:0]  funcIn,
  output wire [9:0]  funcOut,
  output wire [9:0]  funcOe
);
  // ==========================================================
  // State
  localparam integer FLOAT_CYC_INT = `SPHP_FLOAT_CYC;
  localparam [1:0]   FLOAT_CYC     = FLOAT_CYC_INT[1:0];

  reg  [1:0] mode;
  reg  [1:0] nibbleDir;
  reg  [7:0] portDir;
  reg  [7:0] nibbleOut;
  reg  [7:0] inLatch;
  reg  [7:0] outLatch;
  reg        inputFullFlag;
  reg        outputFullN;
  reg        busDrive;
  reg  [1:0] floatCnt;
  reg        strobePrev;
  reg        ackPrev;
  reg        rdPrev;
  reg        wrPrev;
  wire [7:0] syncData;
  wire [7:0] syncCtl;
  wire       inputStrobeN;
  wire       ackN;

  assign inputStrobeN = syncCtl[`SPHP_BIT_STROBE];
  assign ackN         = syncCtl[`SPHP_BIT_ACK];
  assign hostPortIn   = syncData;
  assign hostNibbleIn = syncCtl;

  // ==========================================================
  // Pin synchronisers; data shares the strobe's delay so the
  // latched byte lines up with the synced strobe
  sphp_sync #(
    .WIDTH  (8),
    .RSTVAL (`SPHP_RST_PINS)
  ) uSyncData (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   (dataIn),
    .syncOut (syncData)
  );

  sphp_sync #(
    .WIDTH  (8),
    .RSTVAL (`SPHP_RST_PINS)
  ) uSyncCtl (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   (ctlIn),
    .syncOut (syncCtl)
  );

  // ==========================================================
  // Edge detection
  wire strobeLow  = ~inputStrobeN;
  wire strobeRise = ~strobePrev & inputStrobeN;
  wire ackFall    = ackPrev & ~ackN;
  wire ackRise    = ~ackPrev & ackN;
  wire rdFall     = rdPrev & ~hostRdN;
  wire rdRise     = ~rdPrev & hostRdN;
  wire wrFall     = wrPrev & ~hostWrN;
  wire wrRise     = ~wrPrev & hostWrN;

  wire inMode     = (mode == `SPHP_MODE_STB_IN) || (mode == `SPHP_MODE_BIDIR);
  wire outMode    = (mode == `SPHP_MODE_STB_OUT) || (mode == `SPHP_MODE_BIDIR);

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      strobePrev <= 1'b1;
      ackPrev    <= 1'b1;
      rdPrev     <= 1'b1;
      wrPrev     <= 1'b1;
      mode       <= `SPHP_MODE_BASIC;
      nibbleDir  <= `SPHP_RST_NIBDIR;
      portDir    <= `SPHP_RST_BYTE;
      nibbleOut  <= `SPHP_RST_BYTE;
    end
    else
    begin
      strobePrev <= inputStrobeN;
      ackPrev    <= ackN;
      rdPrev     <= hostRdN;
      wrPrev     <= hostWrN;
      mode       <= hostMode;
      nibbleDir  <= hostNibbleDir;
      portDir    <= hostPortDir;
      nibbleOut  <= hostNibbleOut;
    end
  end

  // ==========================================================
  // Input side: latch and input-full flag
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      inLatch       <= `SPHP_RST_BYTE;
      inputFullFlag <= 1'b0;
      hostRdData    <= `SPHP_RST_BYTE;
    end
    else
    begin
      if (inMode && strobeLow)
        inLatch <= syncData;
      if (rdFall)
        hostRdData <= inLatch;
      // Set wins over a clear in the same cycle
      if (inMode && strobeLow)
        inputFullFlag <= 1'b1;
      else if (inMode && rdRise)
        inputFullFlag <= 1'b0;
      else if (!inMode)
        inputFullFlag <= 1'b0;
    end
  end

  // ==========================================================
  // Output side: latch and active-low output-full flag
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      outLatch    <= `SPHP_RST_BYTE;
      outputFullN <= 1'b1;
    end
    else
    begin
      if (outMode && wrRise)
        outLatch <= hostWrData;
      // A fresh write wins over an acknowledge of the previous byte
      if (outMode && wrRise)
        outputFullN <= 1'b0;
      else if (ackFall || !outMode)
        outputFullN <= 1'b1;
    end
  end

  // ==========================================================
  // Service request
  wire sreqSet = (mode == `SPHP_MODE_STB_IN  && strobeRise && hostInEnable)
              || (mode == `SPHP_MODE_STB_OUT && ackRise && hostOutEnable)
              || (mode == `SPHP_MODE_BIDIR   && ((strobeRise && hostInEnable)
                                             || (ackRise && hostOutEnable)));
  wire sreqClr = (inMode && rdFall) || (outMode && wrFall) || (mode == `SPHP_MODE_BASIC);

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      serviceRequest <= 1'b0;
    else if (sreqSet)
      serviceRequest <= 1'b1;
    else if (sreqClr)
      serviceRequest <= 1'b0;
  end

  // ==========================================================
  // Shared bus drive in bidirectional mode; release is held off
  // by a short count so the far end sees the byte past its edge
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      busDrive <= 1'b0;
      floatCnt <= 2'h0;
    end
    else if (mode != `SPHP_MODE_BIDIR)
    begin
      busDrive <= 1'b0;
      floatCnt <= 2'h0;
    end
    else if (!ackN)
    begin
      busDrive <= 1'b1;
      floatCnt <= FLOAT_CYC;
    end
    else if (floatCnt != 2'h0)
      floatCnt <= floatCnt - 2'h1;
    else
      busDrive <= 1'b0;
  end

  // ==========================================================
  // Pin drive; every enable derives from reset-cleared flops
  always @*
  begin
    dataOut = outLatch;
    dataOe  = 8'h00;
    case (mode)
      `SPHP_MODE_BASIC:
      begin
        dataOut = nibbleOut;
        dataOe  = portDir;
      end
      `SPHP_MODE_STB_IN:
        dataOe = 8'h00;
      `SPHP_MODE_STB_OUT:
        dataOe = 8'hFF;
      `SPHP_MODE_BIDIR:
        dataOe = {8{busDrive}};
      default:
        dataOe = 8'h00;
    endcase
  end

  always @*
  begin
    ctlOut = nibbleOut;
    ctlOe  = {{4{nibbleDir[1]}}, {4{nibbleDir[0]}}};
    case (mode)
      `SPHP_MODE_BASIC:
        ctlOut = nibbleOut;
      `SPHP_MODE_STB_IN:
      begin
        ctlOut[`SPHP_BIT_INFULL] = inputFullFlag;
        ctlOe[`SPHP_BIT_INFULL]  = 1'b1;
        ctlOe[`SPHP_BIT_STROBE]  = 1'b0;
        ctlOut[`SPHP_BIT_SREQ]   = serviceRequest;
        ctlOe[`SPHP_BIT_SREQ]    = 1'b1;
      end
      `SPHP_MODE_STB_OUT:
      begin
        ctlOut[`SPHP_BIT_OUTFULL] = outputFullN;
        ctlOe[`SPHP_BIT_OUTFULL]  = 1'b1;
        ctlOe[`SPHP_BIT_ACK]      = 1'b0;
        ctlOut[`SPHP_BIT_SREQ]    = serviceRequest;
        ctlOe[`SPHP_BIT_SREQ]     = 1'b1;
      end
      `SPHP_MODE_BIDIR:
      begin
        ctlOut[`SPHP_BIT_OUTFULL] = outputFullN;
        ctlOe[`SPHP_BIT_OUTFULL]  = 1'b1;
        ctlOe[`SPHP_BIT_ACK]      = 1'b0;
        ctlOut[`SPHP_BIT_INFULL]  = inputFullFlag;
        ctlOe[`SPHP_BIT_INFULL]   = 1'b1;
        ctlOe[`SPHP_BIT_STROBE]   = 1'b0;
        ctlOut[`SPHP_BIT_SREQ]    = serviceRequest;
        ctlOe[`SPHP_BIT_SREQ]     = 1'b1;
      end
      default:
        ctlOe = 8'h00;
    endcase
  end

  // ==========================================================
  // General-purpose and programmable-function lines
  sphp_gpio #(
    .WIDTH (8)
  ) uGpio (
    .clk_sys (clk_sys),
    .rst     (rst),
    .hostDir (hostGpioDir),
    .hostOut (hostGpioOut),
    .pinIn   (gpioIn),
    .pinOut  (gpioOut),
    .pinOe   (gpioOe),
    .lineIn  (hostGpioIn)
  );

  sphp_gpio #(
    .WIDTH (10)
  ) uFunc (
    .clk_sys (clk_sys),
    .rst     (rst),
    .hostDir (hostFuncDir),
    .hostOut (hostFuncOut),
    .pinIn   (funcIn),
    .pinOut  (funcOut),
    .pinOe   (funcOe),
    .lineIn  (hostFuncIn)
  );
endmodule
`default_nettype wire

// ==== verilog/sphp_regs.vh ====
/*
  Constants of the strobed parallel handshake port: mode codes, control-line
  positions, reset values and timing counts. Assumes a 10 MHz system clock.
*/
`ifndef SPHP_REGS_VH
`define SPHP_REGS_VH

// ==========================================================
// Modes
`define SPHP_MODE_BASIC   2'h0
`define SPHP_MODE_STB_IN  2'h1
`define SPHP_MODE_STB_OUT 2'h2
`define SPHP_MODE_BIDIR   2'h3

// ==========================================================
// Control port line positions
`define SPHP_BIT_OUTFULL  7
`define SPHP_BIT_ACK      6
`define SPHP_BIT_INFULL   5
`define SPHP_BIT_STROBE   4
`define SPHP_BIT_SREQ     3

// ==========================================================
// Reset values
`define SPHP_RST_BYTE     8'h00
`define SPHP_RST_PINS     8'hFF
`define SPHP_RST_NIBDIR   2'h0

// ==========================================================
// Timing
`define SPHP_CLK_NS       100
`define SPHP_CYC_MAX(ns)  (((ns) / `SPHP_CLK_NS) > 0 ? ((ns) / `SPHP_CLK_NS) : 1)
`define SPHP_CYC_MIN(ns)  ((((ns) + `SPHP_CLK_NS - 1) / `SPHP_CLK_NS) > 0 ? \
                           (((ns) + `SPHP_CLK_NS - 1) / `SPHP_CLK_NS) : 1)
`define SPHP_IBF_SET_NS   150
`define SPHP_FLOAT_MIN_NS 20
`define SPHP_FLOAT_MAX_NS 250
`define SPHP_FLOAT_CYC    `SPHP_CYC_MIN(`SPHP_FLOAT_MIN_NS)

`endif

// ==== verilog/sphp_sync.v ====
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module sphp_sync #(
  parameter WIDTH              = 8,
  parameter [WIDTH-1:0] RSTVAL = {WIDTH{1'b1}}
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] syncOut
);
  // ==========================================================
  // Per-bit stages; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gSync
      reg stage1;
      reg stage2;
      always @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          stage1 <= RSTVAL[i];
          stage2 <= RSTVAL[i];
        end
        else
        begin
          stage1 <= pinIn[i];
          stage2 <= stage1;
        end
      end
      assign syncOut[i] = stage2;
    end
  endgenerate
endmodule
`default_nettype wire
